// File: core/sirq_pkg.sv
// Purpose: shared constants and types of the serialized irq link
// Assumes: host end makes the link clock from a 100 MHz core clock
// Notes:   clock c=0 is the high clock that closes the start frame
`default_nettype none
package sirq_pkg;
   // clock figures
   localparam int CORE_PERIOD_NS = 10;  // core clock period
   localparam int LCLK_PERIOD_NS = 80;  // link clock period
   localparam int LCLK_HALF_CYC  = LCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);
   // frame layout
   localparam int NUM_IRQ    = 7;       // irq 3,4,5,7,9,10,11
   localparam int NUM_FRAMES = 32;      // data frames in a cycle
   localparam int FRAME_CLKS = 3;       // sample, recovery, turn-around
   localparam logic [3:0] START_MIN  = 4'h4;  // least start low clocks
   localparam logic [3:0] START_MAX  = 4'h8;  // most start low clocks
   localparam logic [3:0] STOP_QUIET = 4'h2;  // stop low, quiet next
   localparam logic [3:0] STOP_CONT  = 4'h3;  // stop low, continuous next
   // sample clocks past start; bit 0 is irq3 up to bit 6 irq11
   localparam logic [6:0][7:0] SAMPLE_PT = {8'h23, 8'h20, 8'h1d, 8'h17, 8'h11, 8'h0e, 8'h0b};
   localparam logic RST_QUIET = 1'b0;   // continuous mode after reset
   localparam logic [7:0] CNT_ONE = 8'h01;
   // device link states
   typedef enum logic [1:0] {D_IDLE, D_PULSE, D_WAIT, D_ACTIVE} sirq_dev_state_type;
   // host link states
   typedef enum logic [2:0] {H_IDLE, H_START, H_FRAMES, H_STOP, H_STOPHI} sirq_host_state_type;
endpackage : sirq_pkg
`default_nettype wire

// File: core/sirq_link_if.sv
// Purpose: shared serialized irq line between host end and device end
// Assumes: a released line is held high by a pull-up
// Notes:   host drive wins if both ends drive at once
`timescale 1ns/100ps
`default_nettype none
interface sirq_link_if;
   logic lclk;     // link clock, made by the host end
   logic lrst_n;   // bus reset, active low
   logic host_oe;  // host drives the line
   logic host_o;   // host drive level
   logic dev_oe;   // device drives the line
   logic dev_o;    // device drive level
   logic serirq;   // resolved line level
   // pull-up when nobody drives
   assign serirq = host_oe ? host_o : (dev_oe ? dev_o : 1'b1);
   modport host (output lclk, output lrst_n, output host_oe, output host_o, input serirq);
   modport dev  (input lclk, input lrst_n, input serirq, output dev_oe, output dev_o);
endinterface : sirq_link_if
`default_nettype wire

// File: core/sirq_dev_end.sv
// Purpose: device end of the serialized irq line
// Assumes: i_irq_req is a level set of core-clock logic
// Notes:   link logic runs on the link clock and bus reset only
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: line released unless a cycle needs it
// R2: line timed and sampled on link clock
// R3: start frame is four to eight clocks low
// R4: continuous mode start comes from host only
// R5: reset gives continuous mode, wait host start
// R6: quiet mode device start is one-clock pulse
// R7: host extends pulse by three to seven clocks
// R8: host ends start low with one high clock
// R9: no start while a cycle is active
// R10: count clocks from start to find frames
// R11: each frame is sample, recovery, turn-around
// R12: sample phase low when irq pending, else released
// R13: recovery high one clock, turn-around released
// R14: only irq 3,4,5,7,9,10,11 are signalled
// R15: irq3, irq4, irq5 sample at 11, 14, 17
// R16: irq7 23, irq9 29, irq10 32, irq11 35
// R17: unassigned frames never driven until stop
// R18: host alone ends cycle, two or three low
// R19: stop length two quiet, three continuous
// R20: quiet start only on changed request, idle line
// R21: irq levels taken from registered snapshot
module sirq_dev_end (
   sirq_link_if.dev              link,
   input  wire logic             i_core_clk,
   input  wire logic             i_rstn,
   input  wire logic [6:0]       i_irq_req,
   output logic                  o_quiet_mode,
   output logic                  o_cycle_active
);

   // link-clock state
   typedef struct packed {
      sirq_pkg::sirq_dev_state_type st;  // link state
      logic [7:0]                   cnt;   // clock index past start
      logic [3:0]                   run;   // low run length
      logic                         quiet; // mode of next cycle
      logic                         act;   // cycle active flag
      logic [6:0]                   s1;    // request sync stage 1
      logic [6:0]                   s2;    // request sync stage 2
      logic [6:0]                   s3;    // request sync stage 3
      logic [6:0]                   pend;  // accepted requests
      logic [6:0]                   rep;   // snapshot being reported
      logic                         oe;    // line drive enable
      logic                         o;     // line drive level
   } sirq_dev_link_type;

   // core-clock state
   typedef struct packed {
      logic [6:0]                   req;   // registered requests
      logic [2:0]                   qsy;   // quiet mode sync chain
      logic [2:0]                   asy;   // active flag sync chain
      logic                         qa;    // accepted quiet mode
      logic                         aa;    // accepted active flag
   } sirq_dev_core_type;

   localparam sirq_dev_link_type LINK_RST = '{
      st:    sirq_pkg::D_IDLE,
      cnt:   8'h00,
      run:   4'h0,
      quiet: sirq_pkg::RST_QUIET,
      act:   1'b0,
      s1:    7'h00,
      s2:    7'h00,
      s3:    7'h00,
      pend:  7'h00,
      rep:   7'h00,
      oe:    1'b0,
      o:     1'b1
   };

   localparam sirq_dev_core_type CORE_RST = '{
      req:   7'h00,
      qsy:   {3{sirq_pkg::RST_QUIET}},
      asy:   3'h0,
      qa:    sirq_pkg::RST_QUIET,
      aa:    1'b0
   };

   sirq_dev_link_type lr;        // link state register
   sirq_dev_link_type ln;        // link state next value
   sirq_dev_core_type cr;        // core state register
   sirq_dev_core_type cn;        // core state next value
   logic [7:0]        cnt_nx;    // clock index of the next period
   logic              line_hi;   // line level of the period just ended

   // link side: the line is sampled on each rising link clock
   always_comb begin
      ln      = lr;
      line_hi = link.serirq;       // [R2]
      cnt_nx  = lr.cnt + sirq_pkg::CNT_ONE;
      // requests cross from the core clock, three stages
      ln.s1   = cr.req;
      ln.s2   = lr.s1;
      ln.s3   = lr.s2;
      for (int i = 0; i < sirq_pkg::NUM_IRQ; i++) begin
         // take a bit only once stages two and three agree
         if (lr.s2[i] == lr.s3[i]) begin
            ln.pend[i] = lr.s3[i];
         end
      end
      // released by default, only the pulse and slots below turn it on
      ln.oe = 1'b0;               // [R1]
      ln.o  = 1'b1;
      // low run length, saturating so long lows stay long
      if (!line_hi) begin
         if (lr.run != 4'hf) begin
            ln.run = lr.run + 4'h1;
         end
      end else begin
         ln.run = 4'h0;
      end
      case (lr.st)
         // idle, or waiting for the host to take over our pulse
         sirq_pkg::D_IDLE, sirq_pkg::D_WAIT: begin
            if (line_hi && lr.run >= sirq_pkg::START_MIN) begin
               // high after four or more lows closes a start frame
               ln.st  = sirq_pkg::D_ACTIVE;  // [R3] [R5]
               ln.cnt = sirq_pkg::CNT_ONE;   // [R10]
               // freeze levels so each sample clock is steady
               ln.rep = lr.pend;             // [R21]
            end else if (lr.st == sirq_pkg::D_WAIT && line_hi) begin
               // host did not extend the pulse; retry from idle
               ln.st = sirq_pkg::D_IDLE;
            end else if (lr.st == sirq_pkg::D_IDLE && line_hi &&
                         lr.run == 4'h0 && lr.quiet &&
                         lr.pend != lr.rep) begin
               // quiet mode, idle line, changed request: one low clock
               ln.st = sirq_pkg::D_PULSE;    // [R6] [R9] [R20] [R4]
               ln.oe = 1'b1;
               ln.o  = 1'b0;
            end
         end
         // pulse clock is on the line now; release at once
         sirq_pkg::D_PULSE: begin
            ln.st = sirq_pkg::D_WAIT;        // [R6]
         end
         // cycle running: count clocks and serve our frames
         sirq_pkg::D_ACTIVE: begin
            if (lr.cnt != 8'hff) begin
               ln.cnt = cnt_nx;              // [R10]
            end
            for (int i = 0; i < sirq_pkg::NUM_IRQ; i++) begin
               // only the seven listed slots exist here; all
               // other frames, unassigned ones too, stay released
               if (cnt_nx == sirq_pkg::SAMPLE_PT[i] && lr.rep[i]) begin
                  // sample phase of a pending irq
                  ln.oe = 1'b1;              // [R11] [R12] [R14] [R15] [R16] [R17]
                  ln.o  = 1'b0;
               end
               if (cnt_nx == sirq_pkg::SAMPLE_PT[i] + sirq_pkg::CNT_ONE) begin
                  // recovery phase drives high; turn-around falls out
                  ln.oe = 1'b1;              // [R11] [R13]
                  ln.o  = 1'b1;
               end
            end
            // a low run of two or more can only be the stop frame,
            // since sample lows are always a single clock
            if (line_hi && lr.run >= sirq_pkg::STOP_QUIET) begin
               ln.st    = sirq_pkg::D_IDLE;  // [R9]
               ln.quiet = (lr.run == sirq_pkg::STOP_QUIET);  // [R19]
               ln.oe    = 1'b0;              // [R1]
               ln.o     = 1'b1;
            end
         end
         default: begin
            ln.st = sirq_pkg::D_IDLE;
         end
      endcase
      ln.act = (ln.st == sirq_pkg::D_ACTIVE);
   end

   // link register, reset by the bus reset
   always_ff @(posedge link.lclk or negedge link.lrst_n) begin
      if (!link.lrst_n) begin
         lr <= LINK_RST;
      end else begin
         lr <= ln;
      end
   end

   // core side: register requests, bring status back
   always_comb begin
      cn     = cr;
      // same-clock logic, no synchroniser needed
      cn.req = i_irq_req;
      // status crosses from the link clock, three stages
      cn.qsy = {cr.qsy[1:0], lr.quiet};
      cn.asy = {cr.asy[1:0], lr.act};
      if (cr.qsy[1] == cr.qsy[2]) begin
         cn.qa = cr.qsy[2];
      end
      if (cr.asy[1] == cr.asy[2]) begin
         cn.aa = cr.asy[2];
      end
   end

   // core register
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cr <= CORE_RST;
      end else begin
         cr <= cn;
      end
   end

   // outputs straight from flops
   assign link.dev_oe    = lr.oe;
   assign link.dev_o     = lr.o;
   assign o_quiet_mode   = cr.qa;
   assign o_cycle_active = cr.aa;

endmodule : sirq_dev_end
`default_nettype wire

// File: core/sirq_host_end.sv
// Purpose: host end of the serialized irq line
// Assumes: one core clock; the link clock is divided from it
// Notes:   decisions at link rise, drive applied at link fall
`timescale 1ns/100ps
`default_nettype none
module sirq_host_end #(
   parameter int                 DIV_HALF   = sirq_pkg::LCLK_HALF_CYC,
   parameter logic [3:0]         START_CLKS = sirq_pkg::START_MIN,
   parameter int                 N_FRAMES   = sirq_pkg::NUM_FRAMES
) (
   sirq_link_if.host             link,
   input  wire logic             i_core_clk,
   input  wire logic             i_rstn,
   input  wire logic             i_start,
   input  wire logic             i_quiet_sel,
   output logic [N_FRAMES-1:0]   o_irq_frames,
   output logic                  o_frames_valid,
   output logic                  o_busy,
   output logic                  o_quiet_mode
);

   localparam logic [7:0] DIV_LAST = 8'(DIV_HALF - 1);
   localparam logic [7:0] STOP_AT  = 8'(sirq_pkg::FRAME_CLKS * N_FRAMES + 2);

   typedef struct packed {
      logic [7:0]                    div;    // divider count
      logic                          lclk;   // link clock
      logic                          lrst_n; // bus reset out
      logic                          s1;     // line sync stages
      logic                          s2;
      logic                          s3;
      logic                          line;   // accepted line level
      sirq_pkg::sirq_host_state_type st;     // link state
      logic [7:0]                    cnt;    // low count or clock index
      logic                          quiet;  // current mode
      logic                          sel;    // mode chosen at stop
      logic                          req;    // start request pending
      logic                          poe;    // drive for this period
      logic                          po;
      logic                          oe;     // drive on the line
      logic                          o;
      logic [N_FRAMES-1:0]           frames; // frames seen low
      logic [N_FRAMES-1:0]           irqv;   // last finished cycle
      logic                          valid;  // result strobe
   } sirq_host_type;

   localparam sirq_host_type HOST_RST = '{
      div: 8'h00, lclk: 1'b0, lrst_n: 1'b0, s1: 1'b1, s2: 1'b1, s3: 1'b1,
      line: 1'b1, st: sirq_pkg::H_IDLE, cnt: 8'h00, quiet: sirq_pkg::RST_QUIET,
      sel: 1'b0, req: 1'b0, poe: 1'b0, po: 1'b1, oe: 1'b0, o: 1'b1,
      frames: '0, irqv: '0, valid: 1'b0
   };

   sirq_host_type hr;       // state register
   sirq_host_type hn;       // next value
   logic          tick_rise; // link clock rises at this edge
   logic          dev_go;   // device pulse seen in quiet mode

   // divider, line sync and link state
   always_comb begin
      hn       = hr;
      hn.valid = 1'b0;
      hn.lrst_n = 1'b1;
      tick_rise = 1'b0;
      dev_go   = hr.quiet && !hr.line;
      if (hr.div == DIV_LAST) begin
         hn.div  = 8'h00;
         hn.lclk = ~hr.lclk;
         tick_rise = ~hr.lclk;
         // drive moves at the fall, away from the device sample edge
         if (hr.lclk) begin
            hn.oe = hr.poe;          // [R2]
            hn.o  = hr.po;
         end
      end else begin
         hn.div = hr.div + 8'h01;
      end
      // line comes from another clock: three stages, two agree
      hn.s1 = link.serirq;
      hn.s2 = hr.s1;
      hn.s3 = hr.s2;
      if (hr.s2 == hr.s3) begin
         hn.line = hr.s3;
      end
      if (tick_rise) begin
         case (hr.st)
            sirq_pkg::H_IDLE: begin
               // start only from idle; in quiet mode a device pulse
               // counts as the first low clock
               if (hr.req || dev_go) begin
                  hn.req    = 1'b0;      // [R4] [R9]
                  hn.st     = sirq_pkg::H_START;
                  hn.poe    = 1'b1;
                  hn.po     = 1'b0;
                  hn.cnt    = dev_go ? 8'h02 : 8'h01;  // [R7]
                  hn.frames = '0;
               end
            end
            sirq_pkg::H_START: begin
               if (hr.cnt[3:0] == START_CLKS) begin
                  hn.po  = 1'b1;         // [R3] [R8]
                  hn.cnt = 8'h00;
                  hn.st  = sirq_pkg::H_FRAMES;
               end else begin
                  hn.cnt = hr.cnt + 8'h01;
               end
            end
            sirq_pkg::H_FRAMES: begin
               for (int f = 0; f < N_FRAMES; f++) begin
                  if (hr.cnt == 8'(sirq_pkg::FRAME_CLKS * f + 2)) begin
                     hn.frames[f] = ~hr.line;
                  end
               end
               hn.poe = 1'b0;            // [R8]
               hn.cnt = hr.cnt + 8'h01;
               if (hn.cnt == STOP_AT) begin
                  hn.st  = sirq_pkg::H_STOP;  // [R18]
                  hn.poe = 1'b1;
                  hn.po  = 1'b0;
                  hn.cnt = 8'h01;
                  hn.sel = i_quiet_sel;
               end
            end
            sirq_pkg::H_STOP: begin
               if (hr.cnt[3:0] == (hr.sel ? sirq_pkg::STOP_QUIET : sirq_pkg::STOP_CONT)) begin
                  hn.po = 1'b1;          // [R18] [R19]
                  hn.st = sirq_pkg::H_STOPHI;
               end else begin
                  hn.cnt = hr.cnt + 8'h01;
               end
            end
            sirq_pkg::H_STOPHI: begin
               hn.poe   = 1'b0;
               hn.st    = sirq_pkg::H_IDLE;
               hn.quiet = hr.sel;        // [R19]
               hn.irqv  = hr.frames;
               hn.valid = 1'b1;
            end
            default: begin
               hn.st = sirq_pkg::H_IDLE;
            end
         endcase
      end
      // a new request beats the clear in the same cycle
      if (i_start) begin
         hn.req = 1'b1;
      end
   end

   // state register
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         hr <= HOST_RST;
      end else begin
         hr <= hn;
      end
   end

   assign link.lclk      = hr.lclk;
   assign link.lrst_n    = hr.lrst_n;
   assign link.host_oe   = hr.oe;
   assign link.host_o    = hr.o;
   assign o_irq_frames   = hr.irqv;
   assign o_frames_valid = hr.valid;
   assign o_busy         = (hr.st != sirq_pkg::H_IDLE);
   assign o_quiet_mode   = hr.quiet;

endmodule : sirq_host_end
`default_nettype wire

// File: testbench/sirq_link_props.sv
// Purpose: line checks for the serialized irq link
// Assumes: host end and device end share one link
// Notes:   all checks run on the link clock
`timescale 1ns/100ps
`default_nettype none
module sirq_link_props (
   input wire logic lclk,
   input wire logic lrst_n,
   input wire logic host_oe,
   input wire logic host_o,
   input wire logic dev_oe,
   input wire logic dev_o,
   input wire logic serirq
);
   localparam int STOP_C = 3 * sirq_pkg::NUM_FRAMES + 2; // first stop clock
   logic [3:0] run_r;     // low clocks in a row, saturates
   logic       active_r;  // cycle in progress
   logic       quiet_r;   // mode chosen by last stop
   logic [7:0] cnt_r;     // index of the clock just sampled
   logic       start_end; // high clock after a full start low
   logic       stop_end;  // high clock after the stop low
   logic       smp_slot;  // sample clock of a served irq
   logic       rec_slot;  // recovery clock of a served irq

   default clocking cb @(posedge lclk); endclocking
   default disable iff (!lrst_n);

   // decode the frame position from the running count
   always_comb begin
      start_end = !active_r && serirq && run_r >= 4'h4;
      stop_end  = active_r && serirq && run_r >= 4'h2;
      smp_slot  = cnt_r inside {8'h0b, 8'h0e, 8'h11, 8'h17, 8'h1d, 8'h20, 8'h23};
      rec_slot  = cnt_r inside {8'h0c, 8'h0f, 8'h12, 8'h18, 8'h1e, 8'h21, 8'h24};
   end

   // follow the line as a third listener would, so no design state is trusted
   always_ff @(posedge lclk or negedge lrst_n) begin
      if (!lrst_n) begin
         run_r    <= 4'h0;
         active_r <= 1'b0;
         quiet_r  <= 1'b0;
         cnt_r    <= 8'h00;
      end else begin
         run_r <= serirq ? 4'h0 : (run_r == 4'hf ? run_r : run_r + 4'h1);
         if (start_end) begin
            active_r <= 1'b1;
            cnt_r    <= 8'h01;
         end else if (stop_end) begin
            active_r <= 1'b0;
            quiet_r  <= (run_r == 4'h2);
         end else if (active_r) begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end

   sequence s_host_close;
      host_oe && host_o ##1 !host_oe;
   endsequence
   sequence s_frame_tail;
      dev_oe && dev_o ##1 !dev_oe;
   endsequence

   a_start_len: assert property (
      !active_r && serirq && run_r != 4'h0 |-> run_r >= 4'h4 && run_r <= 4'h8)
      else $error("start low length out of range");
   a_start_close: assert property (start_end |-> s_host_close)
      else $error("start not closed by one high clock");
   a_no_restart: assert property (active_r && cnt_r < STOP_C |-> !host_oe)
      else $error("host drove the line inside a cycle");
   a_stop_len: assert property (stop_end |->
      (run_r == 4'h2 && cnt_r == STOP_C + 2) || (run_r == 4'h3 && cnt_r == STOP_C + 3))
      else $error("stop frame badly placed or sized");
   a_low_one: assert property (dev_oe && !dev_o |=> !dev_oe || dev_o)
      else $error("device low drive longer than one clock");
   a_frame_tail: assert property (active_r && dev_oe && !dev_o |=> s_frame_tail)
      else $error("sample not followed by recovery and turn-around");
   a_rec_high: assert property (active_r && rec_slot |-> dev_oe && dev_o)
      else $error("recovery clock not driven high");
   a_sample_slot: assert property (active_r && dev_oe && !dev_o |-> smp_slot)
      else $error("device low outside its sample clocks");
   a_tail_quiet: assert property (active_r && cnt_r > 8'h24 |-> !dev_oe)
      else $error("device drove an unassigned frame");
   a_idle_pulse: assert property (!active_r && dev_oe |-> !dev_o && quiet_r)
      else $error("device drove an idle line wrongly");
endmodule : sirq_link_props
`default_nettype wire

// File: testbench/test_serialized_irq_agent.sv
// Purpose: host end and device end joined over one link
// Assumes: pull-up on the line inside the interface
// Notes:   inputs change 1 ns after the core clock rises
`timescale 1ns/100ps
`default_nettype none
module test_serialized_irq_agent;
   localparam int SMP_CLK [7] = '{11, 14, 17, 23, 29, 32, 35}; // sample clocks
   logic        core_clk;     // 100 MHz core clock
   logic        rstn;         // shared reset, active low
   logic [6:0]  irq_req;      // pending requests
   logic        start_req;    // host start pulse
   logic        quiet_sel;    // stop length choice
   logic [31:0] irq_frames;   // frames seen low by the host
   logic        frames_valid; // frame word updated
   logic        host_busy;    // host inside a cycle
   logic        host_quiet;   // host mode
   logic        dev_quiet;    // device mode
   logic        dev_active;   // device inside a cycle
   logic        ok;           // completion seen in time
   int          n_fail;       // mismatches
   int          checks_done;  // comparisons

   sirq_link_if link_bus ();
   sirq_host_end u_sirq_host_end (.link(link_bus), .i_core_clk(core_clk), .i_rstn(rstn),
      .i_start(start_req), .i_quiet_sel(quiet_sel), .o_irq_frames(irq_frames),
      .o_frames_valid(frames_valid), .o_busy(host_busy), .o_quiet_mode(host_quiet));
   sirq_dev_end u_sirq_dev_end (.link(link_bus), .i_core_clk(core_clk), .i_rstn(rstn),
      .i_irq_req(irq_req), .o_quiet_mode(dev_quiet), .o_cycle_active(dev_active));
   sirq_link_props u_sirq_link_props (.lclk(link_bus.lclk), .lrst_n(link_bus.lrst_n),
      .host_oe(link_bus.host_oe), .host_o(link_bus.host_o), .dev_oe(link_bus.dev_oe),
      .dev_o(link_bus.dev_o), .serirq(link_bus.serirq));

   // free-running core clock
   always #5 core_clk = ~core_clk;

   // expected frame word: frame n holds bit n-1, frame n samples at 3n-1
   function automatic logic [31:0] exp_of(input logic [6:0] irq);
      logic [31:0] e;
      e = 32'h0;
      for (int k = 0; k < 7; k++) begin
         if (irq[k]) begin
            e[(SMP_CLK[k] + 1) / 3 - 1] = 1'b1;
         end
      end
      return e;
   endfunction : exp_of

   // wait n core edges, then step off the edge
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // bounded wait for the host's frame word; a cycle is about 900 core clocks
   task automatic wait_valid();
      ok = 1'b0;
      for (int i = 0; i < 3000 && !ok; i++) begin
         step(1);
         if (frames_valid === 1'b1) begin
            ok = 1'b1;
         end
      end
   endtask : wait_valid

   // one full cycle, started by the host or by a changed request
   task automatic run_cycle(input logic strt, input logic [6:0] irq, input logic qsel);
      irq_req = irq;
      quiet_sel = qsel;
      step(40);
      start_req = strt;
      step(1);
      start_req = 1'b0;
      step(200);
      check("dev_active", 1, dev_active);
      check("host_busy", 1, host_busy);
      wait_valid();
      check("frames_valid", 1, ok);
      check("irq_frames", exp_of(irq), irq_frames);
      step(40);
      check("dev_idle", 0, dev_active);
      check("dev_quiet", qsel, dev_quiet);
      check("host_quiet", qsel, host_quiet);
   endtask : run_cycle

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   // main sequence
   initial begin
      core_clk = 1'b0;
      rstn = 1'b0;
      irq_req = 7'h00;
      start_req = 1'b0;
      quiet_sel = 1'b0;
      n_fail = 0;
      checks_done = 0;
      step(10);
      rstn = 1'b1;
      step(2);
      check("dev_quiet", 0, dev_quiet);
      check("serirq", 1, link_bus.serirq);
      run_cycle(1'b1, 7'h00, 1'b0);
      // one irq at a time walks every served frame
      for (int k = 0; k < 7; k++) begin
         run_cycle(1'b1, 7'h01 << k, 1'b0);
      end
      run_cycle(1'b1, 7'h7f, 1'b0);
      run_cycle(1'b1, 7'h7f, 1'b1);
      // quiet mode: a changed request starts the cycle with no host start
      run_cycle(1'b0, 7'h05, 1'b1);
      wait_valid();
      check("quiet_no_change", 0, ok);
      run_cycle(1'b1, 7'h05, 1'b0);
      // continuous mode: a changed request must not start a cycle
      irq_req = 7'h08;
      wait_valid();
      check("cont_no_start", 0, ok);
      finish_test();
   end

   // watchdog, about six times the expected run
   initial begin
      #1000000;
      n_fail++;
      $display("Error watchdog expected done seen hang");
      finish_test();
   end
endmodule : test_serialized_irq_agent
`default_nettype wire
